// ==== include/tmr_pkg.sv ====
// package for the 8-bit timer register and flag block
package tmr_pkg;

  // register addresses on the internal I/O bus (data space)
  localparam logic [7:0] ADDR_COUNTER   = 8'h26;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h6E;
  localparam logic [7:0] ADDR_CMP_A     = 8'h27;
  localparam logic [7:0] ADDR_CMP_B     = 8'h28;
  localparam logic [7:0] ADDR_IRQ_FLAG  = 8'h15;
  localparam logic [7:0] ADDR_CONTROL   = 8'h24;

  // flag and mask bit positions
  localparam int BIT_OVF   = 0;
  localparam int BIT_CMP_A = 1;
  localparam int BIT_CMP_B = 2;
  localparam logic [7:0] MASK_FIELDS = 8'h07;

  // control register fields
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_CS_LSB   = 3;
  localparam int CTL_COMA_LSB = 6;
  localparam int CTL_COMB_LSB = 8;
  localparam int CTL_FOCA     = 10;
  localparam int CTL_FOCB     = 11;

  // reset values and fixed counter points
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [7:0] COUNT_MAX    = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [9:0] PRESC_RST    = 10'h000;

  typedef enum logic [2:0] {
    TMR_NORMAL   = 3'b000,
    TMR_PC_FIXED = 3'b001,
    TMR_CTC      = 3'b010,
    TMR_FAST_FIX = 3'b011,
    TMR_RSV4     = 3'b100,
    TMR_PC_VAR   = 3'b101,
    TMR_RSV6     = 3'b110,
    TMR_FAST_VAR = 3'b111
  } tmr_mode_t;

  // one access on the core's I/O bus
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tmr_bus_t;

  // per-channel compare event for the waveform unit
  typedef struct packed {
    logic       match;
    logic       force_strobe;
    logic       at_top;
    logic       up;
    logic [1:0] com;
  } tmr_wave_t;

endpackage : tmr_pkg

// ==== design/tmr_wave.sv ====
// waveform output generator for one compare channel
`timescale 1ns/1ps
module tmr_wave (
  input  wire logic             i_mclk,
  input  wire logic             i_reset,
  input  wire logic             i_ce,
  input  wire logic             i_pwm,
  input  wire logic             i_phase,
  input  wire tmr_pkg::tmr_wave_t i_ev,
  output logic                  o_wave
);
  import tmr_pkg::*;

  logic wave_q;
  logic wave_d;
  logic hit;

  assign hit = i_ev.match | i_ev.force_strobe;

  always_comb begin
    wave_d = wave_q;
    if (!i_pwm) begin
      if (hit) begin
        case (i_ev.com)
          2'b01:   wave_d = ~wave_q;
          2'b10:   wave_d = 1'b0;
          2'b11:   wave_d = 1'b1;
          default: wave_d = wave_q;
        endcase
      end
    end else if (i_ev.com[1]) begin
      if (i_phase) begin
        if (i_ev.match) begin
          wave_d = i_ev.up ? i_ev.com[0] : ~i_ev.com[0];
        end
      end else if (i_ev.match) begin
        wave_d = i_ev.com[0];
      end else if (i_ev.at_top) begin
        wave_d = ~i_ev.com[0];
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      wave_q <= 1'b0;
    end else if (i_ce) begin
      wave_q <= wave_d;
    end
  end

  assign o_wave = wave_q;

endmodule : tmr_wave

// ==== design/tmr_core.sv ====
// 8-bit timer/counter: counter, compare registers, mask and flag registers
//
// Overview of operation
// - counter register readable and writable at any time
// - counter write blocks next compare match
// - compare A matched continuously, drives flag/wave
// - compare B matched continuously, drives flag/wave
// - mask bits seven to three read zero
// - compare B irq needs mask2, global, flag
// - compare A irq needs mask1, global, flag
// - overflow irq needs mask0, global, flag
// - flag bit two set on B match
// - flag bit one set on A match
// - flag bit zero set on overflow
// - flags clear when matching vector executes
// - writing one clears flag, zero keeps
// - overflow point depends on waveform mode
// - forced strobe changes wave only
`timescale 1ns/1ps
module tmr_core (
  input  wire logic             i_mclk,
  input  wire logic             i_reset,
  input  wire logic             i_ce,
  input  wire tmr_pkg::tmr_bus_t i_bus,
  input  wire logic             i_ctl_wr,
  input  wire logic [11:0]      i_ctl_wdata,
  input  wire logic             i_ext_tick,
  input  wire logic             i_global_ie,
  input  wire logic [2:0]       i_vector_ack,
  output logic [7:0]            o_rdata,
  output logic [2:0]            o_irq_req,
  output logic                  o_wave_output_a,
  output logic                  o_wave_output_b
);
  import tmr_pkg::*;

  function automatic logic [7:0] ld_byte(input logic hit, input logic [7:0] d,
                                         input logic [7:0] q);
    ld_byte = hit ? d : q;
  endfunction : ld_byte

  logic [7:0]  counter_value_q, counter_value_d;
  logic [7:0]  compare_value_a_q, compare_value_b_q;
  logic [2:0]  irq_enable_mask_q;
  logic [2:0]  irq_flag_status_q, irq_flag_status_d;
  logic [7:0]  ctl_q;
  logic [9:0]  presc_q;
  logic        dir_down_q;
  logic        block_q;

  wire  tmr_mode_t wave_mode_select = tmr_mode_t'(ctl_q[CTL_MODE_LSB +: 3]);
  wire  [2:0]  clk_sel   = ctl_q[CTL_CS_LSB +: 3];
  wire  [1:0]  com_a     = ctl_q[CTL_COMA_LSB +: 2];
  logic [1:0]  com_b_q;
  tmr_wave_t   ev_a;
  tmr_wave_t   ev_b;

  wire  wr_counter = i_bus.wr && (i_bus.addr == ADDR_COUNTER);
  wire  wr_mask    = i_bus.wr && (i_bus.addr == ADDR_IRQ_MASK);
  wire  wr_cmp_a   = i_bus.wr && (i_bus.addr == ADDR_CMP_A);
  wire  wr_cmp_b   = i_bus.wr && (i_bus.addr == ADDR_CMP_B);
  wire  wr_flag    = i_bus.wr && (i_bus.addr == ADDR_IRQ_FLAG);

  // timer clock select: prescaled taps or a synchronous external tick
  wire  tick = (clk_sel == 3'd1) ? 1'b1 :
               (clk_sel == 3'd2) ? (presc_q[2:0] == 3'h7) :
               (clk_sel == 3'd3) ? (presc_q[5:0] == 6'h3F) :
               (clk_sel == 3'd4) ? (presc_q[7:0] == 8'hFF) :
               (clk_sel == 3'd5) ? (presc_q == 10'h3FF) :
               (clk_sel >= 3'd6) ? i_ext_tick : 1'b0;

  wire  is_phase = (wave_mode_select == TMR_PC_FIXED) || (wave_mode_select == TMR_PC_VAR);
  wire  is_fast  = (wave_mode_select == TMR_FAST_FIX) || (wave_mode_select == TMR_FAST_VAR);
  wire  is_pwm   = is_phase || is_fast;
  wire  var_top  = (wave_mode_select == TMR_CTC) || (wave_mode_select == TMR_PC_VAR) ||
                   (wave_mode_select == TMR_FAST_VAR);
  wire  [7:0] top_value = var_top ? compare_value_a_q : COUNT_MAX;
  wire  at_top    = (counter_value_q == top_value);
  wire  at_bottom = (counter_value_q == COUNT_BOTTOM);

  // compare matches are evaluated on each timer clock, unless blocked by a write
  wire  match_a = tick && !block_q && (counter_value_q == compare_value_a_q);
  wire  match_b = tick && !block_q && (counter_value_q == compare_value_b_q);

  // overflow point follows the waveform mode
  wire  ovf_evt = tick && (is_phase ? (at_bottom && dir_down_q) :
                  (wave_mode_select == TMR_FAST_VAR) ? at_top :
                  (counter_value_q == COUNT_MAX));

  // forced compares only act in non-PWM modes and bypass flags and CTC clear
  wire  foc_a = i_ctl_wr && i_ctl_wdata[CTL_FOCA] && !is_pwm;
  wire  foc_b = i_ctl_wr && i_ctl_wdata[CTL_FOCB] && !is_pwm;

  always_comb begin
    counter_value_d = counter_value_q;
    if (wr_counter) begin
      counter_value_d = i_bus.wdata;
    end else if (tick) begin
      if (is_phase) begin
        // turn around on the tick that sees top, so top is never overshot
        counter_value_d = (at_top || (dir_down_q && !at_bottom)) ? counter_value_q - 8'h01 :
                          counter_value_q + 8'h01;
      end else if (at_top && var_top) begin
        counter_value_d = COUNT_BOTTOM;
      end else begin
        counter_value_d = counter_value_q + 8'h01;
      end
    end
  end

  wire  [2:0] hw_set = {match_b, match_a, ovf_evt};
  wire  [2:0] sw_clr = wr_flag ? i_bus.wdata[2:0] : 3'b000;

  always_comb begin
    // set is applied last so a coincident event survives any clear
    irq_flag_status_d = (irq_flag_status_q & ~sw_clr & ~i_vector_ack) | hw_set;
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      counter_value_q <= RST_BYTE;
      presc_q         <= PRESC_RST;
      block_q         <= 1'b0;
      dir_down_q      <= 1'b0;
    end else if (i_ce) begin
      counter_value_q <= counter_value_d;
      presc_q         <= presc_q + 10'h001;
      // the block lasts until the next timer clock has been seen
      block_q         <= wr_counter ? 1'b1 : (tick ? 1'b0 : block_q);
      if (!is_phase) begin
        dir_down_q <= 1'b0;
      end else if (tick && at_top) begin
        dir_down_q <= 1'b1;
      end else if (tick && at_bottom) begin
        dir_down_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      compare_value_a_q <= RST_BYTE;
      compare_value_b_q <= RST_BYTE;
      irq_enable_mask_q <= 3'b000;
      irq_flag_status_q <= 3'b000;
      ctl_q             <= RST_BYTE;
      com_b_q           <= 2'b00;
    end else if (i_ce) begin
      compare_value_a_q <= ld_byte(wr_cmp_a, i_bus.wdata, compare_value_a_q);
      compare_value_b_q <= ld_byte(wr_cmp_b, i_bus.wdata, compare_value_b_q);
      if (wr_mask) begin
        irq_enable_mask_q <= i_bus.wdata[2:0];
      end
      irq_flag_status_q <= irq_flag_status_d;
      ctl_q             <= ld_byte(i_ctl_wr, i_ctl_wdata[7:0], ctl_q);
      if (i_ctl_wr) begin
        com_b_q <= i_ctl_wdata[CTL_COMB_LSB +: 2];
      end
    end
  end

  // interrupt request needs enable, global enable and flag together
  assign o_irq_req[BIT_CMP_B] = irq_enable_mask_q[BIT_CMP_B] & i_global_ie &
                                irq_flag_status_q[BIT_CMP_B];
  assign o_irq_req[BIT_CMP_A] = irq_enable_mask_q[BIT_CMP_A] & i_global_ie &
                                irq_flag_status_q[BIT_CMP_A];
  assign o_irq_req[BIT_OVF]   = irq_enable_mask_q[BIT_OVF] & i_global_ie &
                                irq_flag_status_q[BIT_OVF];

  // read mux: combinational, reserved bits zero, unmapped reads zero
  always_comb begin
    o_rdata = 8'h00;
    if (i_bus.rd) begin
      case (i_bus.addr)
        ADDR_COUNTER:  o_rdata = counter_value_q;
        ADDR_CMP_A:    o_rdata = compare_value_a_q;
        ADDR_CMP_B:    o_rdata = compare_value_b_q;
        ADDR_IRQ_MASK: o_rdata = {5'b00000, irq_enable_mask_q};
        ADDR_IRQ_FLAG: o_rdata = {5'b00000, irq_flag_status_q};
        default:       o_rdata = 8'h00;
      endcase
    end
  end

  // compare events handed to the two waveform units
  assign ev_a = '{match: match_a, force_strobe: foc_a, at_top: tick && at_top,
                  up: !dir_down_q, com: com_a};
  assign ev_b = '{match: match_b, force_strobe: foc_b, at_top: tick && at_top,
                  up: !dir_down_q, com: com_b_q};

  tmr_wave u_wave_a (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_ce    (i_ce),
    .i_pwm   (is_pwm),
    .i_phase (is_phase),
    .i_ev    (ev_a),
    .o_wave  (o_wave_output_a)
  );

  tmr_wave u_wave_b (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_ce    (i_ce),
    .i_pwm   (is_pwm),
    .i_phase (is_phase),
    .i_ev    (ev_b),
    .o_wave  (o_wave_output_b)
  );

endmodule : tmr_core

// ==== sim/tmr_monitor.sv ====
// assertion checker on the timer register block ports
`timescale 1ns/1ps
module tmr_monitor (
  input wire logic              i_mclk,
  input wire logic              i_reset,
  input wire logic              i_ce,
  input wire tmr_pkg::tmr_bus_t i_bus,
  input wire logic              i_ctl_wr,
  input wire logic [11:0]       i_ctl_wdata,
  input wire logic              i_ext_tick,
  input wire logic              i_global_ie,
  input wire logic [2:0]        i_vector_ack,
  input wire logic [7:0]        o_rdata,
  input wire logic [2:0]        o_irq_req,
  input wire logic              o_wave_output_a,
  input wire logic              o_wave_output_b
);
  import tmr_pkg::*;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  wire rd_mask = i_bus.rd && i_bus.addr == ADDR_IRQ_MASK;
  wire rd_flag = i_bus.rd && i_bus.addr == ADDR_IRQ_FLAG;
  property p_back(logic [7:0] a);
    (i_ce && i_bus.wr && i_bus.addr == a) ##1 (i_bus.rd && i_bus.addr == a)
      |-> o_rdata == $past(i_bus.wdata);
  endproperty
  a_count_readback: assert property (p_back(ADDR_COUNTER))
    else $error("counter read differs from write");
  a_cmpa_readback: assert property (p_back(ADDR_CMP_A))
    else $error("compare A read differs from write");
  a_cmpb_readback: assert property (p_back(ADDR_CMP_B))
    else $error("compare B read differs from write");
  a_mask_readback: assert property ((i_ce && i_bus.wr && i_bus.addr == ADDR_IRQ_MASK) ##1 rd_mask
    |-> o_rdata == ($past(i_bus.wdata) & MASK_FIELDS))
    else $error("mask read differs from write");
  a_mask_rsvd_zero: assert property (rd_mask |-> o_rdata[7:3] == 5'h00)
    else $error("mask reserved bits not zero");
  a_irq_needs_global: assert property (o_irq_req != 3'h0 |-> i_global_ie)
    else $error("irq request without global enable");
  a_irq_needs_flag: assert property (rd_flag |-> (o_irq_req & ~o_rdata[2:0]) == 3'h0)
    else $error("irq request without its flag");
  a_idle_rdata_zero: assert property (!i_bus.rd |-> o_rdata == 8'h00)
    else $error("read data without read strobe");
  a_wave_frozen: assert property (!i_ce |=> $stable({o_wave_output_a, o_wave_output_b}))
    else $error("wave output moved with clock enable low");
  c_irq: cover property (o_irq_req != 3'h0);
  c_wave: cover property ($rose(o_wave_output_a));
  c_flag: cover property (rd_flag && o_rdata != 8'h00);
endmodule : tmr_monitor

bind tmr_core tmr_monitor u_mon (.i_mclk(i_mclk), .i_reset(i_reset), .i_ce(i_ce),
  .i_bus(i_bus), .i_ctl_wr(i_ctl_wr), .i_ctl_wdata(i_ctl_wdata), .i_ext_tick(i_ext_tick),
  .i_global_ie(i_global_ie), .i_vector_ack(i_vector_ack), .o_rdata(o_rdata),
  .o_irq_req(o_irq_req), .o_wave_output_a(o_wave_output_a), .o_wave_output_b(o_wave_output_b));

// ==== sim/tmr_cpu_model.sv ====
// processor core model issuing accesses on the timer's I/O bus
`timescale 1ns/1ps
module tmr_cpu_model (
  input  wire logic         i_mclk,
  input  wire logic [7:0]   i_rdata,
  output tmr_pkg::tmr_bus_t o_bus
);
  import tmr_pkg::*;
  initial o_bus = '0;
  // the request stays up after return so accesses can run back to back
  task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(negedge i_mclk);
    o_bus = '{wr: w, rd: r, addr: a, wdata: d};
    @(posedge i_mclk);
    q = i_rdata;
  endtask : acc
  task automatic idle();
    @(negedge i_mclk);
    o_bus = '0;
  endtask : idle
endmodule : tmr_cpu_model

// ==== sim/tmr_core_tb.sv ====
// self-checking bench for the timer register block
`timescale 1ns/1ps
module tmr_core_tb;
  import tmr_pkg::*;
  logic        i_mclk, i_reset, i_ce, i_ctl_wr, i_global_ie, o_wave_output_a, o_wave_output_b;
  logic [11:0] i_ctl_wdata;
  logic [2:0]  i_vector_ack, o_irq_req;
  logic [7:0]  o_rdata, q;
  tmr_bus_t    i_bus;
  int          fails = 0, num_checks = 0, cycles = 0;
  tmr_core dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_ce(i_ce), .i_bus(i_bus),
    .i_ctl_wr(i_ctl_wr), .i_ctl_wdata(i_ctl_wdata), .i_ext_tick(1'b0),
    .i_global_ie(i_global_ie), .i_vector_ack(i_vector_ack), .o_rdata(o_rdata),
    .o_irq_req(o_irq_req), .o_wave_output_a(o_wave_output_a), .o_wave_output_b(o_wave_output_b));
  tmr_cpu_model cpu (.i_mclk(i_mclk), .i_rdata(o_rdata), .o_bus(i_bus));
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  task automatic end_of_test();
    if (fails == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cpu.acc(1'b1, 1'b0, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    cpu.acc(1'b0, 1'b1, a, 8'h00, q);
    chk(q, e);
  endtask : rd
  task automatic ctl(input logic [11:0] w);
    cpu.idle();
    i_ctl_wr = 1'b1;
    i_ctl_wdata = w;
    @(negedge i_mclk);
    i_ctl_wr = 1'b0;
  endtask : ctl
  task automatic t_reset_rw();
    logic [7:0] adr [6] = '{ADDR_COUNTER, ADDR_IRQ_MASK, ADDR_CMP_A, ADDR_CMP_B,
                            ADDR_IRQ_FLAG, 8'h30};
    foreach (adr[k]) rd(adr[k], 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(adr[k], 8'hFF);
      rd(adr[k], (k == 1) ? MASK_FIELDS : 8'hFF);
    end
    wr(adr[5], 8'hFF);
    rd(adr[5], 8'h00);
  endtask : t_reset_rw
  task automatic t_match();
    wr(ADDR_CMP_A, 8'h05);
    wr(ADDR_CMP_B, 8'h0A);
    wr(ADDR_COUNTER, 8'h00);
    ctl(12'h008);
    cpu.idle();
    repeat (30) @(negedge i_mclk);
    ctl(12'h000);
    rd(ADDR_IRQ_FLAG, 8'h06);
    cpu.idle();
    chk({5'h00, o_irq_req}, 8'h00);
    i_global_ie = 1'b1;
    @(negedge i_mclk);
    chk({5'h00, o_irq_req}, 8'h06);
    wr(ADDR_IRQ_FLAG, 8'h02);
    rd(ADDR_IRQ_FLAG, 8'h04);
    wr(ADDR_IRQ_FLAG, 8'h00);
    rd(ADDR_IRQ_FLAG, 8'h04);
    cpu.idle();
    i_vector_ack = 3'b100;
    @(negedge i_mclk);
    i_vector_ack = 3'b000;
    rd(ADDR_IRQ_FLAG, 8'h00);
  endtask : t_match
  task automatic t_overflow();
    wr(ADDR_COUNTER, 8'hFE);
    ctl(12'h008);
    cpu.idle();
    repeat (2) @(negedge i_mclk);
    ctl(12'h000);
    rd(ADDR_IRQ_FLAG, 8'h01);
    cpu.idle();
    chk({5'h00, o_irq_req}, 8'h01);
    wr(ADDR_IRQ_FLAG, 8'h07);
  endtask : t_overflow
  task automatic t_blocked();
    wr(ADDR_COUNTER, 8'h80);
    ctl(12'h008);
    // written while running so the match on the very next tick is the one to lose
    wr(ADDR_COUNTER, 8'h05);
    ctl(12'h000);
    rd(ADDR_IRQ_FLAG, 8'h00);
  endtask : t_blocked
  task automatic t_set_wins();
    wr(ADDR_COUNTER, 8'h04);
    ctl(12'h008);
    // this clear lands on the same edge as the compare-A match at count five
    wr(ADDR_IRQ_FLAG, 8'h02);
    ctl(12'h000);
    rd(ADDR_IRQ_FLAG, 8'h02);
    wr(ADDR_IRQ_FLAG, 8'h07);
  endtask : t_set_wins
  task automatic t_force();
    cpu.idle();
    i_ce = 1'b0;
    ctl(12'h440);
    i_ce = 1'b1;
    chk({7'h00, o_wave_output_a}, 8'h00);
    ctl(12'h040);
    ctl(12'h440);
    repeat (2) @(negedge i_mclk);
    chk({7'h00, o_wave_output_a}, 8'h01);
    ctl(12'h140);
    ctl(12'h940);
    @(negedge i_mclk);
    chk({7'h00, o_wave_output_b}, 8'h01);
    chk({7'h00, o_wave_output_a}, 8'h01);
    rd(ADDR_IRQ_FLAG, 8'h00);
  endtask : t_force
  initial begin
    i_reset = 1'b1;
    i_ce = 1'b1;
    i_ctl_wr = 1'b0;
    i_ctl_wdata = 12'h000;
    i_global_ie = 1'b0;
    i_vector_ack = 3'b000;
    repeat (8) @(negedge i_mclk);
    i_reset = 1'b0;
    t_reset_rw();
    t_match();
    t_overflow();
    t_blocked();
    t_set_wins();
    t_force();
    end_of_test();
  end
endmodule : tmr_core_tb
